/* File: rtl/ipcp_buf_mem.sv */
// Small byte memory holding one packet, read data from a register.
// Assumes one write and one read per clock; read data lag the address by one.
`timescale 1ns/1ps
module ipcp_buf_mem #(
  parameter int DEPTH = 32
) (
  input  wire logic clk,
  ipcp_mem_if.mem   port
);
  logic [7:0] mem_q [DEPTH];

  // No reset: contents are only read after being written
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
    port.rdata <= mem_q[port.raddr];
  end
endmodule

/* File: rtl/ipcp_mem_if.sv */
// Write port and registered read port of one packet buffer.
// Assumes the controller and the memory share one clock.
`timescale 1ns/1ps
interface ipcp_mem_if #(parameter int AW = 5);
  logic          we;
  logic [AW-1:0] waddr;
  logic [7:0]    wdata;
  logic [AW-1:0] raddr;
  logic [7:0]    rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

/* File: rtl/ipcp_pkg.sv */
// Constants, types and helpers shared by the packet command port design.
// Assumes a 200 MHz system clock and a host that drives SCL at 100 kHz or less.
// What this block does
// - Address byte: 7-bit address, LSB selects read
// - Default target address is 0x2A
// - Command 0x21 sets address; 0x04 saves it
// - Up and down held four seconds shows address
// - Packet: type, count, payload, then check value
// - Type: two category bits, six code bits
// - Category 00 command in, 01 response out
// - Category 10 reports, 11 error responses
// - Payload count byte, at most 18 bytes
// - 16-bit check follows payload, low byte first
// - Reads past the end repeat last byte
// - Full input buffer NAKs and drops bytes
// - Result ready within 5 ms of command
// - Every command that passes its checks answered, code echoed back
// - Ping with at most 16 payload bytes echoed with type 0x40
package ipcp_pkg;

  localparam logic [6:0]  ADDR_DEFAULT     = 7'h2a;
  localparam logic [1:0]  CAT_CMD          = 2'h0;
  localparam logic [1:0]  CAT_RESP         = 2'h1;
  localparam logic [1:0]  CAT_REPORT       = 2'h2;
  localparam logic [1:0]  CAT_ERR          = 2'h3;
  localparam logic [5:0]  CODE_PING        = 6'h00;
  localparam logic [5:0]  CODE_SAVE_BOOT   = 6'h04;
  localparam logic [5:0]  CODE_SET_ADDR    = 6'h21;
  localparam logic [7:0]  MAX_PAYLOAD      = 8'h12;
  localparam logic [7:0]  PING_MAX_PAYLOAD = 8'h10;
  localparam logic [7:0]  PKT_OVERHEAD     = 8'h04;
  localparam logic [4:0]  PKT_MAX_BYTES    = 5'h16;
  localparam logic [15:0] CRC_INIT         = 16'hffff;
  localparam logic [15:0] CRC_POLY         = 16'h8408;
  // Register value left after a packet plus its own inverted check, low first
  localparam logic [15:0] CRC_RESIDUE      = 16'hf0b8;

  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned SCL_MAX_KHZ    = 100;
  localparam int unsigned EXEC_LIMIT_US  = 5000;
  localparam int unsigned EXEC_LIMIT_CYC = EXEC_LIMIT_US * CLK_KHZ / 1000;
  localparam int unsigned KEY_HOLD_MS    = 4000;
  localparam int unsigned KEY_HOLD_CYC   = KEY_HOLD_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_AACK = 3'b010,
    I_WR   = 3'b011,
    I_WACK = 3'b100,
    I_RD   = 3'b101,
    I_RACK = 3'b110
  } ipcp_i2c_e;

  typedef enum logic [1:0] {
    EX_IDLE  = 2'b00,
    EX_CHECK = 2'b01,
    EX_EMIT  = 2'b10,
    EX_WAIT  = 2'b11
  } ipcp_exec_e;

  function automatic logic [15:0] ipcp_crc_byte(input logic [15:0] crc,
                                                input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

/* File: rtl/ipcp_top.sv */
// I2C target that takes checked command packets and queues the answers.
// Assumes SCL, SDA and keys come from pins; SDA is open drain outside.
`timescale 1ns/1ps
module ipcp_top import ipcp_pkg::*; #(
  parameter int unsigned EXEC_LIMIT = EXEC_LIMIT_CYC,
  parameter int unsigned KEY_HOLD   = KEY_HOLD_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_drv,
  output logic            sda_oe_n,
  input  wire logic       key_up,
  input  wire logic       key_down,
  output logic            show_addr,
  output logic [6:0]      show_addr_val,
  output logic            save_req,
  output logic [6:0]      save_addr
);

  logic       scl_m_q, scl_s_q, scl_p_q;
  logic       sda_m_q, sda_s_q, sda_p_q;
  logic [1:0] key_m_q, key_s_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      key_m_q <= 2'h0;
      key_s_q <= 2'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda, sda_m_q, sda_s_q};
      key_m_q <= {key_up, key_down};
      key_s_q <= key_m_q;
    end
  end

  wire logic scl_rise  = scl_s_q & ~scl_p_q;
  wire logic scl_fall  = ~scl_s_q & scl_p_q;
  wire logic start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire logic stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  ipcp_mem_if #(.AW(5)) in_bus ();
  ipcp_mem_if #(.AW(5)) out_bus ();

  ipcp_buf_mem #(.DEPTH(32)) u_in_mem (
    .clk  (clk),
    .port (in_bus.mem)
  );
  ipcp_buf_mem #(.DEPTH(32)) u_out_mem (
    .clk  (clk),
    .port (out_bus.mem)
  );

  ipcp_i2c_e   i2c_q;
  ipcp_exec_e  ex_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q, tx_q;
  logic        oe_n_q, rw_q, rd_active_q, pkt_done_q;
  logic [4:0]  in_cnt_q, rd_ptr_q, out_len_q, owp_q;
  logic [15:0] rx_crc_q, ocrc_q;
  logic [7:0]  rx_type_q, rx_len_q, rx_arg_q, rtype_q;
  logic [4:0]  e_q, rlen_q;
  logic [6:0]  addr_q;

  wire logic       exec_busy = ex_q != EX_IDLE;
  wire logic       byte_end  = scl_fall & (bit_q == 4'h8);
  wire logic       addr_hit  = (sh_q[7:1] == addr_q) & ~(exec_busy & ~sh_q[0]);
  wire logic       in_full   = (in_cnt_q == PKT_MAX_BYTES) | exec_busy;
  wire logic       wr_take   = (i2c_q == I_WR) & byte_end & ~in_full;
  wire logic [7:0] rd_byte   = out_bus.rdata;
  wire logic [4:0] rd_next   = rd_ptr_q + 5'h1;
  wire logic       rd_more   = rd_next < out_len_q;

  assign in_bus.we     = wr_take;
  assign in_bus.waddr  = in_cnt_q;
  assign in_bus.wdata  = sh_q;
  assign in_bus.raddr  = e_q;
  assign out_bus.raddr = rd_ptr_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      i2c_q       <= I_IDLE;
      bit_q       <= 4'h0;
      sh_q        <= 8'h00;
      tx_q        <= 8'h00;
      oe_n_q      <= 1'b1;
      rw_q        <= 1'b0;
      rd_active_q <= 1'b0;
      pkt_done_q  <= 1'b0;
      in_cnt_q    <= 5'h00;
      rd_ptr_q    <= 5'h00;
      rx_crc_q    <= CRC_INIT;
      rx_type_q   <= 8'h00;
      rx_len_q    <= 8'h00;
      rx_arg_q    <= 8'h00;
    end else begin
      pkt_done_q <= 1'b0;
      if (start_det) begin
        i2c_q       <= I_ADDR;
        bit_q       <= 4'h0;
        oe_n_q      <= 1'b1;
        rd_active_q <= 1'b0;
      end else if (stop_det) begin
        i2c_q       <= I_IDLE;
        oe_n_q      <= 1'b1;
        rd_active_q <= 1'b0;
        // A whole packet ends at STOP
        pkt_done_q  <= ((i2c_q == I_WR) | (i2c_q == I_WACK)) & ~rw_q &
                       (in_cnt_q != 5'h00);
      end else begin
        case (i2c_q)
          I_ADDR, I_WR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s_q};
              bit_q <= bit_q + 4'h1;
            end else if (byte_end && i2c_q == I_ADDR) begin
              // Upper seven bits address, LSB direction
              if (addr_hit) begin
                oe_n_q   <= 1'b0;
                rw_q     <= sh_q[0];
                rd_ptr_q <= 5'h00;
                i2c_q    <= I_AACK;
                if (!sh_q[0]) begin
                  in_cnt_q <= 5'h00;
                  rx_crc_q <= CRC_INIT;
                end
              end else begin
                i2c_q <= I_IDLE;
              end
            end else if (byte_end) begin
              i2c_q <= I_WACK;
              // Full buffer leaves SDA released and drops the byte
              if (!in_full) begin
                oe_n_q   <= 1'b0;
                in_cnt_q <= in_cnt_q + 5'h1;
                rx_crc_q <= ipcp_crc_byte(rx_crc_q, sh_q);
                // Type, count, then first payload byte
                if (in_cnt_q == 5'h00) begin
                  rx_type_q <= sh_q;
                end
                if (in_cnt_q == 5'h01) begin
                  rx_len_q <= sh_q;
                end
                if (in_cnt_q == 5'h02) begin
                  rx_arg_q <= sh_q;
                end
              end
            end
          end
          I_AACK: begin
            if (scl_fall) begin
              bit_q <= 4'h0;
              if (rw_q) begin
                tx_q        <= rd_byte;
                oe_n_q      <= rd_byte[7];
                rd_active_q <= 1'b1;
                i2c_q       <= I_RD;
              end else begin
                oe_n_q <= 1'b1;
                i2c_q  <= I_WR;
              end
            end
          end
          I_WACK: begin
            if (scl_fall) begin
              oe_n_q <= 1'b1;
              bit_q  <= 4'h0;
              i2c_q  <= I_WR;
            end
          end
          I_RD: begin
            if (scl_rise) begin
              bit_q <= bit_q + 4'h1;
            end else if (byte_end) begin
              oe_n_q <= 1'b1;
              i2c_q  <= I_RACK;
            end else if (scl_fall) begin
              tx_q   <= {tx_q[6:0], 1'b0};
              oe_n_q <= tx_q[6];
            end
          end
          I_RACK: begin
            if (scl_rise) begin
              if (sda_s_q) begin
                i2c_q <= I_IDLE;
              end else if (rd_more) begin
                rd_ptr_q <= rd_next;
              end
              // Past the end the pointer holds
            end else if (scl_fall) begin
              tx_q   <= rd_byte;
              oe_n_q <= rd_byte[7];
              bit_q  <= 4'h0;
              i2c_q  <= I_RD;
            end
          end
          default: i2c_q <= I_IDLE;
        endcase
      end
    end
  end

  wire logic [1:0] rx_cat    = rx_type_q[7:6];
  wire logic [5:0] rx_code   = rx_type_q[5:0];
  // Oversize count or bad check drops the packet
  wire logic       pkt_ok    = (rx_len_q <= MAX_PAYLOAD) &
                               ({3'h0, in_cnt_q} == rx_len_q + PKT_OVERHEAD) &
                               (rx_crc_q == CRC_RESIDUE);
  wire logic       is_cmd    = rx_cat == CAT_CMD;
  wire logic       ping_ok   = is_cmd & (rx_code == CODE_PING) &
                               (rx_len_q <= PING_MAX_PAYLOAD);
  wire logic       setad_ok  = is_cmd & (rx_code == CODE_SET_ADDR) &
                               (rx_len_q == 8'h01) & ~rx_arg_q[7];
  wire logic       save_ok   = is_cmd & (rx_code == CODE_SAVE_BOOT) &
                               (rx_len_q == 8'h00);
  wire logic       cmd_ok    = ping_ok | setad_ok | save_ok;
  // Code echoed under response or error category
  wire logic [7:0] resp_type = {cmd_ok ? CAT_RESP : CAT_ERR, rx_code};
  wire logic [4:0] resp_len  = ping_ok ? rx_len_q[4:0] : 5'h00;

  // Check value follows the payload, low byte first
  wire logic [7:0] fi_byte   = (e_q == 5'h00) ? rtype_q :
                               (e_q == 5'h01) ? {3'h0, rlen_q} :
                               (e_q < rlen_q + 5'h2) ? in_bus.rdata :
                               (e_q == rlen_q + 5'h2) ? ~ocrc_q[7:0] :
                               ~ocrc_q[15:8];
  wire logic       fi_valid  = ex_q == EX_EMIT;
  wire logic [8:0] fi_data   = {e_q == 5'h00, fi_byte};
  wire logic       fi_ready;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ex_q        <= EX_IDLE;
      e_q         <= 5'h00;
      rtype_q     <= 8'h00;
      rlen_q      <= 5'h00;
      ocrc_q      <= CRC_INIT;
      addr_q      <= ADDR_DEFAULT;
      save_req    <= 1'b0;
      save_addr   <= ADDR_DEFAULT;
    end else begin
      save_req <= 1'b0;
      case (ex_q)
        EX_IDLE: begin
          if (pkt_done_q) begin
            ex_q <= EX_CHECK;
          end
        end
        EX_CHECK: begin
          if (pkt_ok) begin
            rtype_q <= resp_type;
            rlen_q  <= resp_len;
            e_q     <= 5'h00;
            ocrc_q  <= CRC_INIT;
            ex_q    <= EX_EMIT;
            if (setad_ok) begin
              addr_q <= rx_arg_q[6:0];
            end
            if (save_ok) begin
              save_req  <= 1'b1;
              save_addr <= addr_q;
            end
          end else begin
            ex_q <= EX_IDLE;
          end
        end
        EX_EMIT: begin
          // Stalls here while the answer buffer is full
          if (fi_ready) begin
            e_q <= e_q + 5'h1;
            if (e_q < rlen_q + 5'h2) begin
              ocrc_q <= ipcp_crc_byte(ocrc_q, fi_byte);
            end
            ex_q <= (e_q == rlen_q + 5'h3) ? EX_IDLE : EX_WAIT;
          end
        end
        EX_WAIT: ex_q <= EX_EMIT;
        default: ex_q <= EX_IDLE;
      endcase
    end
  end

  // Two-entry buffer toward the answer memory
  logic [8:0] f0_q, f1_q;
  logic [1:0] fcnt_q;
  // Never rewrite the answer while the host is reading it
  wire logic       fo_ready = ~rd_active_q;
  wire logic       fo_valid = fcnt_q != 2'h0;
  wire logic       f_push   = fi_valid & fi_ready;
  wire logic       f_pop    = fo_valid & fo_ready;
  wire logic [8:0] f0_d     = f_pop ? ((fcnt_q == 2'h2) ? f1_q : fi_data) :
                              ((fcnt_q == 2'h0) ? fi_data : f0_q);
  wire logic       f1_load  = f_push & (f_pop ? (fcnt_q == 2'h2) :
                                                (fcnt_q == 2'h1));
  wire logic [4:0] ow_addr  = f0_q[8] ? 5'h00 : owp_q;
  assign fi_ready = fcnt_q != 2'h2;

  assign out_bus.we    = f_pop;
  assign out_bus.waddr = ow_addr;
  assign out_bus.wdata = f0_q[7:0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      f0_q      <= 9'h000;
      f1_q      <= 9'h000;
      fcnt_q    <= 2'h0;
      owp_q     <= 5'h00;
      out_len_q <= 5'h00;
    end else begin
      f0_q   <= f0_d;
      f1_q   <= f1_load ? fi_data : f1_q;
      fcnt_q <= fcnt_q + {1'b0, f_push} - {1'b0, f_pop};
      if (f_pop) begin
        owp_q     <= ow_addr + 5'h1;
        out_len_q <= ow_addr + 5'h1;
      end
    end
  end

  // Address display after both keys are held long enough
  logic [29:0] key_cnt_q;
  wire logic   both_keys = &key_s_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      key_cnt_q     <= 30'h0;
      show_addr     <= 1'b0;
      show_addr_val <= ADDR_DEFAULT;
      sda_drv       <= 1'b0;
      sda_oe_n      <= 1'b1;
    end else begin
      sda_drv       <= 1'b0;
      sda_oe_n      <= oe_n_q;
      show_addr_val <= addr_q;
      if (!both_keys) begin
        key_cnt_q <= 30'h0;
        show_addr <= 1'b0;
      end else if (key_cnt_q != 30'(KEY_HOLD - 1)) begin
        key_cnt_q <= key_cnt_q + 30'h1;
      end else begin
        show_addr <= 1'b1;
      end
    end
  end

  // Helper for the execution time check
  logic [31:0] exec_cyc_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      exec_cyc_q <= 32'h0;
    end else begin
      exec_cyc_q <= exec_busy ? exec_cyc_q + 32'h1 : 32'h0;
    end
  end

  // Check run over the bytes as queued, so the sent order is verified
  logic [15:0]      ans_crc_q;
  wire logic [15:0] ans_crc_base = (e_q == 5'h00) ? CRC_INIT : ans_crc_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ans_crc_q <= CRC_INIT;
    end else if (f_push) begin
      ans_crc_q <= ipcp_crc_byte(ans_crc_base, fi_byte);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_addr_ack: assert property (
    i2c_q == I_ADDR && byte_end && sh_q[7:1] == addr_q && sh_q[0]
    |=> !oe_n_q && i2c_q == I_AACK && rw_q)
    else $error("matching read address not acknowledged");
  chk_nak_full: assert property (
    i2c_q == I_WR && byte_end && in_cnt_q == PKT_MAX_BYTES
    |=> oe_n_q && $stable(in_cnt_q) ##1 oe_n_q)
    else $error("byte taken into a full input buffer");
  chk_drop_bad: assert property (
    ex_q == EX_CHECK && !pkt_ok |=> ex_q == EX_IDLE ##1 !fi_valid)
    else $error("bad packet produced an answer");
  chk_code_echo: assert property (
    f_push && e_q == 5'h00
    |-> fi_byte[5:0] == rx_code && fi_byte[7:6] != CAT_CMD)
    else $error("answer type does not echo command code");
  chk_ping_type: assert property (
    ex_q == EX_CHECK && pkt_ok && ping_ok
    |=> rtype_q == 8'h40 && {3'h0, rlen_q} == $past(rx_len_q))
    else $error("ping not echoed as type 0x40");
  chk_exec_time: assert property (
    exec_cyc_q < EXEC_LIMIT)
    else $error("command took longer than the execution limit");
  chk_read_repeat: assert property (
    i2c_q == I_RACK && scl_rise && !sda_s_q && !rd_more
    |=> $stable(rd_ptr_q))
    else $error("read pointer moved past the last byte");
  chk_set_addr: assert property (
    ex_q == EX_CHECK && pkt_ok && setad_ok
    |=> {1'b0, addr_q} == $past(rx_arg_q))
    else $error("address command did not change the address");
  chk_crc_low_first: assert property (
    f_push && e_q == rlen_q + 5'h2 |-> fi_byte == ~ocrc_q[7:0]
    ##[1:3] f_push && fi_byte == ~ocrc_q[15:8])
    else $error("check value not sent low byte first");
  chk_crc_residue: assert property (
    f_push && e_q == rlen_q + 5'h3 |=> ans_crc_q == CRC_RESIDUE)
    else $error("answer check value does not close the packet");
  chk_key_show: assert property (
    $rose(show_addr) |-> $past(both_keys, 2) && both_keys)
    else $error("address shown without both keys held");

  cov_ping_done: cover property (
    ex_q == EX_EMIT && rtype_q == 8'h40 && rlen_q != 5'h00 ##1 ex_q == EX_IDLE);
  cov_full_nak: cover property (wr_take ##[1:1000] i2c_q == I_WR && byte_end
    && in_cnt_q == PKT_MAX_BYTES);
  cov_addr_change: cover property (ex_q == EX_CHECK && pkt_ok && setad_ok);
  cov_fifo_full: cover property (fcnt_q == 2'h2 && !fo_ready);

endmodule

/* File: sim/i2c_packet_command_port_tb_top.sv */
// Self-checking bench: host model on the bus, answer model in queues.
// Assumes ipcp_pkg, ipcp_top and the host model are compiled first.
`timescale 1ns/1ps
module i2c_packet_command_port_tb_top import ipcp_pkg::*;;
  typedef logic [7:0] ipcp_bytes_t[$];
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        scl;
  logic        sda_rel;
  logic        sda_drv;
  logic        sda_oe_n;
  logic        key_up = 1'b0;
  logic        key_down = 1'b0;
  logic        show_addr;
  logic        save_req;
  logic [6:0]  show_addr_val;
  logic [6:0]  save_addr;
  logic [6:0]  cur_addr = ADDR_DEFAULT;
  int          miscompares = 0;
  int          compares = 0;
  int          saves = 0;
  int          exp_saves = 0;
  ipcp_bytes_t last_ans;
  wire         sda = sda_rel & (sda_oe_n | sda_drv);

  always #2.5 clk = ~clk;

  ipcp_top #(.EXEC_LIMIT(200), .KEY_HOLD(50)) DUT (
    .clk(clk), .reset(reset), .scl(scl), .sda(sda), .sda_drv(sda_drv),
    .sda_oe_n(sda_oe_n), .key_up(key_up), .key_down(key_down),
    .show_addr(show_addr), .show_addr_val(show_addr_val),
    .save_req(save_req), .save_addr(save_addr));
  ipcp_host_model host (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [15:0] crc_of(ipcp_bytes_t p);
    logic [15:0] c;
    c = 16'hffff;
    foreach (p[i]) begin
      for (int k = 0; k < 8; k++) begin
        c = (c >> 1) ^ ((c[0] ^ p[i][k]) ? 16'h8408 : 16'h0000);
      end
    end
    return ~c;
  endfunction

  function automatic ipcp_bytes_t seal(ipcp_bytes_t p);
    logic [15:0] c;
    c = crc_of(p);
    p.push_back(c[7:0]);
    p.push_back(c[15:8]);
    return p;
  endfunction

  // Answer model: a packet that fails framing or check leaves no answer
  function automatic void model(ipcp_bytes_t p);
    ipcp_bytes_t a;
    int n;
    if (p.size() < 4) return;
    n = p[1];
    if (n > 18 || p.size() != n + 4) return;
    if (crc_of(p[0:n+1]) !== {p[n+3], p[n+2]}) return;
    a = '{{2'b11, p[0][5:0]}, 8'h00};
    if (p[0] == 8'h00 && n <= 16) begin
      a = p[0:n+1];
      a[0] = 8'h40;
    end else if (p[0] == 8'h21 && n == 1 && !p[2][7]) begin
      a = '{8'h61, 8'h00};
      cur_addr = p[2][6:0];
    end else if (p[0] == 8'h04 && n == 0) begin
      a = '{8'h44, 8'h00};
      exp_saves++;
    end
    last_ans = seal(a);
  endfunction

  // nak_exp: index of first NAKed byte, address byte at 0, -1 for none
  task automatic put(ipcp_bytes_t p, logic [6:0] a, int nak_exp);
    ipcp_bytes_t q;
    logic ack;
    int nak_at;
    q = p;
    q.push_front({a, 1'b0});
    nak_at = -1;
    #1.3;
    host.start();
    foreach (q[i]) begin
      host.wr_byte(q[i], ack);
      if (!ack && nak_at < 0) nak_at = i;
    end
    host.stop();
    chk("nak position", nak_exp[15:0], nak_at[15:0]);
    if (nak_exp < 0) model(p);
    else if (nak_exp > 0) model(p[0:nak_exp-2]);
    repeat (300) @(posedge clk);
  endtask

  task automatic get(logic [6:0] a);
    logic ack;
    logic [7:0] d;
    int n;
    n = last_ans.size();
    #1.3;
    host.start();
    host.wr_byte({a, 1'b1}, ack);
    chk("read address ack", 1, ack);
    for (int i = 0; i <= n; i++) begin
      host.rd_byte(i == n, d);
      chk("answer byte", last_ans[i < n ? i : n - 1], d);
    end
    host.stop();
    repeat (20) @(posedge clk);
  endtask

  // Sampled mid-cycle so the one-cycle pulse is seen while it stands
  always @(negedge clk) begin
    if (save_req === 1'b1) begin
      saves++;
      chk("saved address", cur_addr, save_addr);
    end
  end

  initial begin
    // Longest clean run is about 480 us with the largest random pings
    #520000;
    miscompares++;
    close_out();
  end

  initial begin
    ipcp_bytes_t p;
    int lens[5];
    logic [6:0] na;
    void'($urandom(32'hfe47));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(negedge clk);
    chk("idle sda", 1, sda_oe_n);
    chk("reset address", 7'h2a, show_addr_val);
    chk("reset save", 0, save_req);
    chk("reset show", 0, show_addr);
    $display("Test reset done");
    lens = '{0, 16, $urandom_range(15, 1), $urandom_range(15, 1), 1};
    foreach (lens[k]) begin
      p = '{8'h00, 8'(lens[k])};
      repeat (lens[k]) p.push_back(8'($urandom));
      put(seal(p), cur_addr, -1);
      get(cur_addr);
    end
    put(seal('{8'h00, 8'h00}), 7'h2b, 0);
    $display("Test ping done");
    p = seal('{8'h00, 8'h02, 8'h5a, 8'ha5});
    p[4] = p[4] ^ 8'h01;
    put(p, cur_addr, -1);
    p = '{8'h00, 8'h13};
    repeat (21) p.push_back(8'($urandom));
    put(p, cur_addr, 23);
    get(cur_addr);
    p = '{8'h00, 8'h12};
    repeat (18) p.push_back(8'($urandom));
    p = seal(p);
    p.push_back(8'h77);
    put(p, cur_addr, 23);
    get(cur_addr);
    $display("Test buffer limits done");
    foreach (lens[k]) begin
      p = '{8'(lens[k] * 13), 8'h00};
      if (k == 4) p = '{8'h21, 8'h01, 8'h80};
      put(seal(p), cur_addr, -1);
      get(cur_addr);
    end
    na = 7'h10 + 7'($urandom_range(95));
    if (na == 7'h2a) na = 7'h2b;
    put(seal('{8'h21, 8'h01, {1'b0, na}}), cur_addr, -1);
    get(cur_addr);
    chk("new address", na, show_addr_val);
    put(seal('{8'h00, 8'h00}), 7'h2a, 0);
    put(seal('{8'h04, 8'h00}), cur_addr, -1);
    get(cur_addr);
    chk("save pulses", exp_saves[15:0], saves[15:0]);
    $display("Test address commands done");
    @(posedge clk);
    key_up <= 1'b1;
    repeat (100) @(negedge clk);
    chk("one key", 0, show_addr);
    @(posedge clk);
    key_down <= 1'b1;
    repeat (45) @(negedge clk);
    chk("early show", 0, show_addr);
    repeat (15) @(negedge clk);
    chk("shown", 1, show_addr);
    chk("shown value", cur_addr, show_addr_val);
    @(posedge clk);
    key_up <= 1'b0;
    repeat (10) @(negedge clk);
    chk("released", 0, show_addr);
    $display("Test keys done");
    close_out();
  end
endmodule

/* File: sim/ipcp_host_model.sv */
// Behavioural host bus master that drives the packet command port.
// Assumes an external pull-up: the bench ANDs sda_rel with the device.
`timescale 1ns/1ps
module ipcp_host_model (
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  // Quarter of the 160 ns bit period; far above the pin limit to keep
  // runs short, the design only needs eight clocks per phase
  localparam realtime QTR = 40.0;

  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic bit_out(input logic b);
    sda_rel = b;
    #QTR scl = 1'b1;
    #(2 * QTR) scl = 1'b0;
    #QTR;
  endtask

  task automatic bit_in(output logic b);
    sda_rel = 1'b1;
    #QTR scl = 1'b1;
    #QTR b = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic start();
    sda_rel = 1'b0;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  // SCL stands high between frames
  task automatic stop();
    sda_rel = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_rel = 1'b1;
    #(2 * QTR);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask

  // A NAK on the final byte tells the device the read is over
  task automatic rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask
endmodule
